// [src/tsa_core.sv]
// temperature sensor alarm core: sequencing, result format, limits, alarms
//
// Overview of operation
// RL1 - power-up results are 13 bits, 0.0625 C
// RL2 - config bit 7 selects 16-bit, 0.0078 C
// RL3 - two select pins give four target addresses
// RL4 - critical alarm when temperature exceeds critical limit
// RL5 - critical limit resets to 147 C
// RL6 - second alarm when temperature exceeds over-limit
// RL7 - each alarm: comparator or latched interrupt
// RL8 - first conversion after power-up takes 6 ms
// RL9 - power-saving mode samples once per second
// RL10 - shutdown mode stops conversions, powers down
// RL11 - results are two's complement, sign first
// RL12 - normal and one-shot conversions take 240 ms
// RL13 - host reaches registers over i2c target port
`timescale 1ns/1ns
module tsa_core #(
	parameter int unsigned P_TICK_CYCLES = tsa_pkg::TICK_CYCLES,
	parameter logic [4:0]  P_ADDR_BASE   = tsa_pkg::ADDR_BASE
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic        i_bus_addr_sel_lo,
	input  wire logic        i_bus_addr_sel_hi,
	input  wire logic [15:0] i_adc_data,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	output logic             o_critical_alarm_out,
	output logic             o_critical_alarm_oe,
	output logic             o_over_alarm_out,
	output logic             o_over_alarm_oe,
	output logic             o_adc_enable,
	output logic             o_samples_per_second_mode
);
	import tsa_pkg::*;

	localparam int unsigned DIV_W = $clog2(P_TICK_CYCLES + 1);

	if (P_TICK_CYCLES < 2) begin : g_chk
		$error("tick divider needs at least two cycles");
	end

	typedef enum logic [4:0] {
		S_FAST = 5'b00001,
		S_CONV = 5'b00010,
		S_SPSC = 5'b00100,
		S_SPSI = 5'b01000,
		S_OFF  = 5'b10000
	} tsa_seq_t;

	// 13-bit results keep the low three bits at zero
	function automatic logic [15:0] fmt_temp(input logic [15:0] raw, input logic res16);
		fmt_temp = res16 ? raw : {raw[15:3], 3'b000};
	endfunction

	// register read decode, unmapped reads as zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [15:0] t,
		input logic [7:0] st, input logic [7:0] c, input logic [15:0] ov, input logic [15:0] cr);
		unique case (a)
			REG_TEMP_HI: rd_mux = t[15:8];
			REG_TEMP_LO: rd_mux = t[7:0];
			REG_STATUS:  rd_mux = st;
			REG_CONFIG:  rd_mux = c;
			REG_OVER_HI: rd_mux = ov[15:8];
			REG_OVER_LO: rd_mux = ov[7:0];
			REG_CRIT_HI: rd_mux = cr[15:8];
			REG_CRIT_LO: rd_mux = cr[7:0];
			default:     rd_mux = 8'h00;
		endcase
	endfunction

	logic [1:0]       sel_lo_sync_reg, sel_hi_sync_reg;
	logic [DIV_W-1:0] div_reg, div_next;
	logic             tick_reg, tick_next;
	tsa_seq_t         seq_reg, seq_next;
	logic [9:0]       cnt_reg, cnt_next;
	logic [7:0]       cfg_reg, cfg_next;
	logic [15:0]      over_lim_reg, over_lim_next, crit_lim_reg, crit_lim_next;
	logic [15:0]      temp_reg, temp_next;
	logic             ready_reg, ready_next;
	logic             over_c_reg, over_c_next, crit_c_reg, crit_c_next;
	logic             over_f_reg, over_f_next, crit_f_reg, crit_f_next;
	logic             crit_oe_reg, crit_oe_next, over_oe_reg, over_oe_next;
	logic             adc_en_reg, adc_en_next, sps_reg, sps_next;
	logic             done;
	logic [15:0]      result;
	logic [7:0]       status, ptr, rd_data, rd_addr;
	logic             wr_valid, rd_valid, sda_oe;
	tsa_wr_t          wr;
	tsa_mode_t        mode, wmode;

	// RL3 address select pins synchronised
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			sel_lo_sync_reg <= 2'b00;
			sel_hi_sync_reg <= 2'b00;
		end else begin
			sel_lo_sync_reg <= {sel_lo_sync_reg[0], i_bus_addr_sel_lo};
			sel_hi_sync_reg <= {sel_hi_sync_reg[0], i_bus_addr_sel_hi};
		end
	end

	// RL13 serial register port
	tsa_i2c_target u_i2c (
		.i_clock    (i_clock),
		.i_rst_n    (i_rst_n),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.i_dev_addr ({P_ADDR_BASE, sel_hi_sync_reg[1], sel_lo_sync_reg[1]}),
		.i_rd_data  (rd_data),
		.o_sda_oe   (sda_oe),
		.o_ptr      (ptr),
		.o_wr_valid (wr_valid),
		.o_wr       (wr),
		.o_rd_valid (rd_valid),
		.o_rd_addr  (rd_addr)
	);

	assign status  = {ready_reg, crit_f_reg, 1'b0, over_f_reg, 4'h0};
	assign rd_data = rd_mux(ptr, temp_reg, status, cfg_reg, over_lim_reg, crit_lim_reg);
	assign mode    = tsa_mode_t'(cfg_reg[CFG_MODE_LSB +: 2]);
	assign wmode   = tsa_mode_t'(wr.data[CFG_MODE_LSB +: 2]);
	// RL1 RL2 RL11 two's complement result format
	assign result  = fmt_temp(i_adc_data, cfg_reg[CFG_RES_BIT]);

	// millisecond tick divider
	always_comb begin
		tick_next = 1'b0;
		div_next  = div_reg + DIV_W'(1);
		if (div_reg == DIV_W'(P_TICK_CYCLES - 1)) begin
			div_next  = '0;
			tick_next = 1'b1;
		end
	end

	// conversion sequencer, registers and alarms
	always_comb begin
		seq_next      = seq_reg;
		cnt_next      = tick_reg ? cnt_reg + 10'h001 : cnt_reg;
		cfg_next      = cfg_reg;
		over_lim_next = over_lim_reg;
		crit_lim_next = crit_lim_reg;
		temp_next     = temp_reg;
		over_c_next   = over_c_reg;
		crit_c_next   = crit_c_reg;
		done          = 1'b0;
		unique case (seq_reg)
			// RL8 fast first conversion
			S_FAST: done = tick_reg && (cnt_reg == FAST_TICKS - 10'h001);
			// RL12 normal conversion time
			S_CONV: done = tick_reg && (cnt_reg == CONV_TICKS - 10'h001);
			// RL9 short conversion then idle to one second
			S_SPSC: done = tick_reg && (cnt_reg == SPS_TICKS - 10'h001);
			S_SPSI: begin
				if (tick_reg && cnt_reg == PERIOD_TICKS - 10'h001) begin
					seq_next = S_SPSC;
					cnt_next = 10'h000;
				end
			end
			S_OFF:  cnt_next = 10'h000;
		endcase
		if (done) begin
			temp_next = result;
			// RL4 critical compare
			crit_c_next = $signed(result) > $signed(crit_lim_reg);
			// RL6 over-limit compare
			over_c_next = $signed(result) > $signed(over_lim_reg);
			unique case (mode)
				MODE_CONT: begin
					seq_next = S_CONV;
					cnt_next = 10'h000;
				end
				MODE_SPS:  seq_next = S_SPSI;
				default: begin
					seq_next = S_OFF;
					cnt_next = 10'h000;
				end
			endcase
		end
		if (wr_valid) begin
			unique case (wr.addr)
				REG_CONFIG: begin
					cfg_next = wr.data & CFG_MASK;
					cnt_next = 10'h000;
					// RL10 shutdown and mode restart
					unique case (wmode)
						MODE_SPS:  seq_next = S_SPSC;
						MODE_SHDN: seq_next = S_OFF;
						default:   seq_next = S_CONV;
					endcase
				end
				REG_OVER_HI: over_lim_next[15:8] = wr.data;
				REG_OVER_LO: over_lim_next[7:0]  = wr.data;
				REG_CRIT_HI: crit_lim_next[15:8] = wr.data;
				REG_CRIT_LO: crit_lim_next[7:0]  = wr.data;
				default: ;
			endcase
		end
		// new result flag, a set beats a read clear
		ready_next = done | (ready_reg &
			~(rd_valid & (rd_addr == REG_TEMP_HI || rd_addr == REG_TEMP_LO)));
		// RL7 latched events cleared by status read, set wins
		crit_f_next = (done & crit_c_next) |
			(crit_f_reg & ~(rd_valid & rd_addr == REG_STATUS));
		over_f_next = (done & over_c_next) |
			(over_f_reg & ~(rd_valid & rd_addr == REG_STATUS));
		// RL7 comparator or interrupt drive
		crit_oe_next = cfg_reg[CFG_CRIT_IRQ] ? crit_f_next : crit_c_next;
		over_oe_next = cfg_reg[CFG_OVER_IRQ] ? over_f_next : over_c_next;
		// RL10 analog front end off while idle
		adc_en_next  = (seq_next != S_OFF) && (seq_next != S_SPSI);
		sps_next     = (mode == MODE_SPS);
	end

	// sequencer and register file state
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			div_reg      <= '0;
			tick_reg     <= 1'b0;
			seq_reg      <= S_FAST;
			cnt_reg      <= 10'h000;
			// RL1 default 13-bit resolution
			cfg_reg      <= CFG_RESET;
			over_lim_reg <= OVER_RESET;
			// RL5 critical limit 147 C
			crit_lim_reg <= CRIT_RESET;
			temp_reg     <= TEMP_RESET;
			ready_reg    <= 1'b0;
			over_c_reg   <= 1'b0;
			crit_c_reg   <= 1'b0;
			over_f_reg   <= 1'b0;
			crit_f_reg   <= 1'b0;
			crit_oe_reg  <= 1'b0;
			over_oe_reg  <= 1'b0;
			adc_en_reg   <= 1'b0;
			sps_reg      <= 1'b0;
		end else begin
			div_reg      <= div_next;
			tick_reg     <= tick_next;
			seq_reg      <= seq_next;
			cnt_reg      <= cnt_next;
			cfg_reg      <= cfg_next;
			over_lim_reg <= over_lim_next;
			crit_lim_reg <= crit_lim_next;
			temp_reg     <= temp_next;
			ready_reg    <= ready_next;
			over_c_reg   <= over_c_next;
			crit_c_reg   <= crit_c_next;
			over_f_reg   <= over_f_next;
			crit_f_reg   <= crit_f_next;
			crit_oe_reg  <= crit_oe_next;
			over_oe_reg  <= over_oe_next;
			adc_en_reg   <= adc_en_next;
			sps_reg      <= sps_next;
		end
	end

	// open-drain pins only ever pull low
	assign o_sda_out                 = 1'b0;
	assign o_sda_oe                  = sda_oe;
	assign o_critical_alarm_out      = 1'b0;
	assign o_critical_alarm_oe       = crit_oe_reg;
	assign o_over_alarm_out          = 1'b0;
	assign o_over_alarm_oe           = over_oe_reg;
	assign o_adc_enable              = adc_en_reg;
	assign o_samples_per_second_mode = sps_reg;
endmodule

// [src/tsa_pkg.sv]
// shared constants and types for the temperature sensor alarm core
package tsa_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned TICK_TIME_MS = 1;
	localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;
	// conversion times in ms, counts in ms ticks
	localparam int unsigned FAST_TIME_MS  = 6;
	localparam int unsigned CONV_TIME_MS  = 240;
	localparam int unsigned SPS_CONV_MS   = 60;
	localparam int unsigned SPS_PERIOD_S  = 1;
	localparam logic [9:0]  FAST_TICKS    = 10'(FAST_TIME_MS / TICK_TIME_MS);
	localparam logic [9:0]  CONV_TICKS    = 10'(CONV_TIME_MS / TICK_TIME_MS);
	localparam logic [9:0]  SPS_TICKS     = 10'(SPS_CONV_MS / TICK_TIME_MS);
	localparam logic [9:0]  PERIOD_TICKS  = 10'(SPS_PERIOD_S * 1000 / TICK_TIME_MS);
	// register offsets
	localparam logic [7:0]  REG_TEMP_HI   = 8'h00;
	localparam logic [7:0]  REG_TEMP_LO   = 8'h01;
	localparam logic [7:0]  REG_STATUS    = 8'h02;
	localparam logic [7:0]  REG_CONFIG    = 8'h03;
	localparam logic [7:0]  REG_OVER_HI   = 8'h04;
	localparam logic [7:0]  REG_OVER_LO   = 8'h05;
	localparam logic [7:0]  REG_CRIT_HI   = 8'h08;
	localparam logic [7:0]  REG_CRIT_LO   = 8'h09;
	// config fields
	localparam int unsigned CFG_RES_BIT   = 7;
	localparam int unsigned CFG_MODE_LSB  = 5;
	localparam int unsigned CFG_OVER_IRQ  = 4;
	localparam int unsigned CFG_CRIT_IRQ  = 2;
	localparam logic [7:0]  CFG_MASK      = 8'hf4;
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	// status fields
	localparam int unsigned STAT_READY    = 7;
	localparam int unsigned STAT_CRIT     = 6;
	localparam int unsigned STAT_OVER     = 4;
	// reset values: 147 C and 64 C at 1/128 C per step
	localparam logic [15:0] CRIT_RESET    = 16'h4980;
	localparam logic [15:0] OVER_RESET    = 16'h2000;
	localparam logic [15:0] TEMP_RESET    = 16'h0000;
	// upper five bits of the target address, value arbitrary
	localparam logic [4:0]  ADDR_BASE     = 5'h09;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	typedef enum logic [1:0] {
		MODE_CONT  = 2'b00,
		MODE_ONE   = 2'b01,
		MODE_SPS   = 2'b10,
		MODE_SHDN  = 2'b11
	} tsa_mode_t;
	// one register write from the serial port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} tsa_wr_t;
endpackage

// [src/tsa_i2c_target.sv]
// i2c target engine: pointer, byte writes and byte reads
`timescale 1ns/1ns
module tsa_i2c_target (
	input  wire logic           i_clock,
	input  wire logic           i_rst_n,
	input  wire logic           i_scl,
	input  wire logic           i_sda,
	input  wire logic [6:0]     i_dev_addr,
	input  wire logic [7:0]     i_rd_data,
	output logic                o_sda_oe,
	output logic [7:0]          o_ptr,
	output logic                o_wr_valid,
	output tsa_pkg::tsa_wr_t    o_wr,
	output logic                o_rd_valid,
	output logic [7:0]          o_rd_addr
);
	import tsa_pkg::*;

	typedef enum logic [5:0] {
		I_IDLE = 6'b000001,
		I_ADDR = 6'b000010,
		I_ACK  = 6'b000100,
		I_WR   = 6'b001000,
		I_RD   = 6'b010000,
		I_RACK = 6'b100000
	} tsa_i2c_st_t;

	logic [1:0]  scl_sync_reg, sda_sync_reg;
	logic        scl_prev_reg, sda_prev_reg;
	tsa_i2c_st_t st_reg, st_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [7:0]  shift_reg, shift_next, tx_reg, tx_next, ptr_reg, ptr_next;
	logic        rw_reg, rw_next, first_reg, first_next, nack_reg, nack_next;
	logic        oe_reg, oe_next, wrv_reg, wrv_next, rdv_reg, rdv_next;
	tsa_wr_t     wr_reg, wr_next;
	logic [7:0]  rda_reg, rda_next;
	logic        scl, sda, scl_rise, scl_fall, start, stop, load;

	// two-stage pin synchronisers plus edge history
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], i_scl};
			sda_sync_reg <= {sda_sync_reg[0], i_sda};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl      = scl_sync_reg[1];
	assign sda      = sda_sync_reg[1];
	assign scl_rise = scl & ~scl_prev_reg;
	assign scl_fall = ~scl & scl_prev_reg;
	assign start    = scl & scl_prev_reg & sda_prev_reg & ~sda;
	assign stop     = scl & scl_prev_reg & ~sda_prev_reg & sda;

	// bit level protocol state
	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		tx_next    = tx_reg;
		ptr_next   = ptr_reg;
		rw_next    = rw_reg;
		first_next = first_reg;
		nack_next  = nack_reg;
		oe_next    = oe_reg;
		wrv_next   = 1'b0;
		wr_next    = wr_reg;
		rdv_next   = 1'b0;
		rda_next   = rda_reg;
		load       = 1'b0;
		if (scl_rise) begin
			shift_next = {shift_reg[6:0], sda};
			cnt_next   = cnt_reg + 4'h1;
			nack_next  = sda;
		end
		if (start) begin
			st_next    = I_ADDR;
			cnt_next   = 4'h0;
			first_next = 1'b1;
			oe_next    = 1'b0;
		end else if (stop) begin
			st_next = I_IDLE;
			oe_next = 1'b0;
		end else if (scl_fall) begin
			unique case (st_reg)
				I_IDLE: oe_next = 1'b0;
				I_ADDR: begin
					if (cnt_reg == BITS_PER_BYTE) begin
						// RL3 RL13 address match
						if (shift_reg[7:1] == i_dev_addr) begin
							st_next = I_ACK;
							rw_next = shift_reg[0];
							oe_next = 1'b1;
						end else begin
							st_next = I_IDLE;
						end
					end
				end
				I_ACK: begin
					cnt_next = 4'h0;
					if (rw_reg) begin
						load = 1'b1;
					end else begin
						st_next = I_WR;
						oe_next = 1'b0;
					end
				end
				I_WR: begin
					if (cnt_reg == BITS_PER_BYTE) begin
						st_next = I_ACK;
						oe_next = 1'b1;
						first_next = 1'b0;
						// RL13 pointer then data bytes
						if (first_reg) begin
							ptr_next = shift_reg;
						end else begin
							wrv_next = 1'b1;
							wr_next  = '{addr: ptr_reg, data: shift_reg};
							ptr_next = ptr_reg + 8'h01;
						end
					end
				end
				I_RD: begin
					if (cnt_reg == BITS_PER_BYTE) begin
						st_next  = I_RACK;
						oe_next  = 1'b0;
						cnt_next = 4'h0;
					end else begin
						tx_next = {tx_reg[6:0], 1'b1};
						oe_next = ~tx_reg[6];
					end
				end
				I_RACK: begin
					if (nack_reg) begin
						st_next = I_IDLE;
					end else begin
						load = 1'b1;
					end
				end
			endcase
		end
		// present the next read byte, msb first
		if (load) begin
			st_next  = I_RD;
			cnt_next = 4'h0;
			tx_next  = i_rd_data;
			oe_next  = ~i_rd_data[7];
			rdv_next = 1'b1;
			rda_next = ptr_reg;
			ptr_next = ptr_reg + 8'h01;
		end
	end

	// protocol registers
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_reg    <= I_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg    <= 8'h00;
			ptr_reg   <= 8'h00;
			rw_reg    <= 1'b0;
			first_reg <= 1'b0;
			nack_reg  <= 1'b0;
			oe_reg    <= 1'b0;
			wrv_reg   <= 1'b0;
			wr_reg    <= '0;
			rdv_reg   <= 1'b0;
			rda_reg   <= 8'h00;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			tx_reg    <= tx_next;
			ptr_reg   <= ptr_next;
			rw_reg    <= rw_next;
			first_reg <= first_next;
			nack_reg  <= nack_next;
			oe_reg    <= oe_next;
			wrv_reg   <= wrv_next;
			wr_reg    <= wr_next;
			rdv_reg   <= rdv_next;
			rda_reg   <= rda_next;
		end
	end

	assign o_sda_oe   = oe_reg;
	assign o_ptr      = ptr_reg;
	assign o_wr_valid = wrv_reg;
	assign o_wr       = wr_reg;
	assign o_rd_valid = rdv_reg;
	assign o_rd_addr  = rda_reg;
endmodule

// [testbench/tsa_core_chk.sv]
// port checker for the temperature sensor alarm core
`timescale 1ns/1ns
module tsa_core_chk #(
	parameter int unsigned P_TICK_CYCLES = 4
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic        i_bus_addr_sel_lo,
	input  wire logic        i_bus_addr_sel_hi,
	input  wire logic [15:0] i_adc_data,
	input  wire logic        o_sda_out,
	input  wire logic        o_sda_oe,
	input  wire logic        o_critical_alarm_out,
	input  wire logic        o_critical_alarm_oe,
	input  wire logic        o_over_alarm_out,
	input  wire logic        o_over_alarm_oe,
	input  wire logic        o_adc_enable,
	input  wire logic        o_samples_per_second_mode
);
	localparam logic [15:0] P = 16'(P_TICK_CYCLES);
	logic        en_d_reg, en_d_next;
	logic        sps_per_reg, sps_per_next;
	logic [15:0] on_cnt_reg, on_cnt_next;
	logic [15:0] per_cnt_reg, per_cnt_next;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// saturating on-time and start-to-start counts
	always_comb begin
		en_d_next    = o_adc_enable;
		on_cnt_next  = o_adc_enable ? on_cnt_reg + {15'h0000, ~&on_cnt_reg} : 16'h0000;
		per_cnt_next = per_cnt_reg + {15'h0000, ~&per_cnt_reg};
		if (o_adc_enable && !en_d_reg) begin
			per_cnt_next = 16'h0001;
		end
		sps_per_next = o_samples_per_second_mode && (sps_per_reg || (o_adc_enable && !en_d_reg));
	end
	// register the helper state
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			en_d_reg    <= 1'b0;
			sps_per_reg <= 1'b0;
			on_cnt_reg  <= 16'h0000;
			per_cnt_reg <= 16'h0000;
		end else begin
			en_d_reg    <= en_d_next;
			sps_per_reg <= sps_per_next;
			on_cnt_reg  <= on_cnt_next;
			per_cnt_reg <= per_cnt_next;
		end
	end
	outs_low_a: assert property (!o_sda_out && !o_critical_alarm_out && !o_over_alarm_out)
		else $error("open-drain data value not low");
	rst_quiet_a: assert property ($rose(i_rst_n) |-> !o_sda_oe && !o_critical_alarm_oe
		&& !o_over_alarm_oe && !o_samples_per_second_mode) else $error("output busy at release");
	first_conv_a: assert property ($rose(i_rst_n) |-> ##[1:2] o_adc_enable)
		else $error("no conversion after release");
	sda_hold_a: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
		else $error("data line moved while clock high");
	sps_on_a: assert property ($fell(o_adc_enable) && o_samples_per_second_mode
		|-> on_cnt_reg >= 59 * P && on_cnt_reg <= 61 * P) else $error("slow mode on-time wrong");
	sps_period_a: assert property ($rose(o_adc_enable) && o_samples_per_second_mode
		&& sps_per_reg |-> per_cnt_reg >= 1000 * P - 1 && per_cnt_reg <= 1000 * P + 1)
		else $error("slow mode period wrong");
	conv_len_a: assert property ($fell(o_adc_enable) && !o_samples_per_second_mode
		&& on_cnt_reg > 100 * P && on_cnt_reg < 300 * P |-> on_cnt_reg >= 239 * P
		&& on_cnt_reg <= 241 * P) else $error("conversion length wrong");
	crit_at_end_a: assert property ($rose(o_critical_alarm_oe) |-> $past(o_adc_enable)
		|| $past(o_adc_enable, 2) || $past(o_adc_enable, 3)) else $error("critical off cycle");
	over_at_end_a: assert property ($rose(o_over_alarm_oe) |-> $past(o_adc_enable)
		|| $past(o_adc_enable, 2) || $past(o_adc_enable, 3)) else $error("over alarm off cycle");
	cover property ($rose(o_critical_alarm_oe));
	cover property ($fell(o_over_alarm_oe));
	cover property ($rose(o_adc_enable) && o_samples_per_second_mode);
endmodule
bind tsa_core tsa_core_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) tsa_core_chk_inst (
	.i_clock, .i_rst_n, .i_scl, .i_sda, .i_bus_addr_sel_lo, .i_bus_addr_sel_hi, .i_adc_data,
	.o_sda_out, .o_sda_oe, .o_critical_alarm_out, .o_critical_alarm_oe, .o_over_alarm_out,
	.o_over_alarm_oe, .o_adc_enable, .o_samples_per_second_mode);

// [testbench/tsa_host_model.sv]
// i2c host controller model driving the target port
`timescale 1ns/1ns
module tsa_host_model (
	input  wire logic i_clock,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	// bus idle: both lines released
	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	// one bit, phases of five clocks, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe <= ~b;
		wt(5);
		o_scl <= 1'b1;
		wt(5);
		r = i_sda;
		wt(5);
		o_scl <= 1'b0;
		wt(5);
	endtask
	// start or repeated start
	task automatic start_c();
		o_sda_oe <= 1'b0;
		wt(5);
		o_scl <= 1'b1;
		wt(5);
		o_sda_oe <= 1'b1;
		wt(5);
		o_scl <= 1'b0;
		wt(5);
	endtask
	task automatic stop_c();
		o_sda_oe <= 1'b1;
		wt(5);
		o_scl <= 1'b1;
		wt(5);
		o_sda_oe <= 1'b0;
		wt(10);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ai, a);
	endtask
	// pointer then writes or a two-byte read
	task automatic access(input logic [6:0] a, input logic [7:0] p, input int n,
		input logic [15:0] d, output logic [15:0] v, output logic ok);
		logic [7:0] q;
		logic       k;
		start_c();
		xfer({a, 1'b0}, 1'b1, q, k);
		ok = ~k;
		if (ok) begin
			xfer(p, 1'b1, q, k);
			for (int j = 0; j < n; j++) begin
				xfer(d[15 - 8 * j -: 8], 1'b1, q, k);
			end
			if (n == 0) begin
				start_c();
				xfer({a, 1'b1}, 1'b1, q, k);
				xfer(8'hff, 1'b0, v[15:8], k);
				xfer(8'hff, 1'b1, v[7:0], k);
			end
		end
		stop_c();
	endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the temperature sensor alarm core
`timescale 1ns/1ns
module tb_top;
	import tsa_pkg::*;
	typedef struct packed {
		logic [7:0]  p;
		logic [1:0]  n;
		logic [15:0] d;
		logic [15:0] e;
	} tsa_row_t;
	localparam int unsigned TICKS = 4;
	localparam int          LIMIT = 80000;
	localparam tsa_row_t ROWS [7] = '{
		{8'h00, 2'h0, 16'h0000, 16'h0c88}, {8'h08, 2'h0, 16'h0000, 16'h4980},
		{8'h04, 2'h0, 16'h0000, 16'h2000}, {8'h03, 2'h0, 16'h0000, 16'h0020},
		{8'h04, 2'h2, 16'h0100, 16'h0100}, {8'h08, 2'h2, 16'h0300, 16'h0300},
		{8'h0a, 2'h2, 16'habcd, 16'h0000}};
	logic        i_clock, i_rst_n, sel_lo, sel_hi, ok;
	logic        scl, sda, host_oe, sda_oe, crit_oe, over_oe, adc_en, samples_per_second_mode;
	logic [15:0] adc, v;
	int          errors, checks, cycles, on;
	tsa_core #(.P_TICK_CYCLES(TICKS)) tsa_core_inst (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
		.i_bus_addr_sel_lo(sel_lo), .i_bus_addr_sel_hi(sel_hi), .i_adc_data(adc),
		.o_sda_out(), .o_sda_oe(sda_oe), .o_critical_alarm_out(),
		.o_critical_alarm_oe(crit_oe), .o_over_alarm_out(), .o_over_alarm_oe(over_oe),
		.o_adc_enable(adc_en), .o_samples_per_second_mode(samples_per_second_mode));
	tsa_host_model tsa_host_model_inst (.i_clock(i_clock), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(host_oe));
	// pulled-up data wire
	assign sda = ~(host_oe | sda_oe);
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [7:0] p, input int n, input logic [15:0] d);
		tsa_host_model_inst.access({ADDR_BASE, sel_hi, sel_lo}, p, n, d, v, ok);
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// cut a hang short
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		{i_rst_n, sel_lo, sel_hi, adc} = {3'h0, 16'h0c8f};
		{errors, checks, cycles} = '0;
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (5) @(posedge i_clock);
		// table: optional write, then readback
		for (int r = 0; r < 7; r++) begin
			if (ROWS[r].n != 2'h0) begin
				acc(ROWS[r].p, ROWS[r].n, ROWS[r].d);
			end
			acc(ROWS[r].p, 0, 16'h0000);
			chk(v, ROWS[r].e);
		end
		$display("test register table done");
		// each select code answers its own address and not the one with sel_lo flipped
		for (int k = 0; k < 4; k++) begin
			{sel_hi, sel_lo} <= 2'(k);
			repeat (5) @(posedge i_clock);
			tsa_host_model_inst.access({ADDR_BASE, 2'(k ^ 1)}, 8'h08, 0, 16'h0000, v, ok);
			chk({15'h0000, ok}, 16'h0000);
			acc(8'h08, 0, 16'h0000);
			chk({v[14:0], ok}, 16'h0601);
		end
		$display("test address select done");
		// comparator mode follows each conversion
		chk({14'h0000, crit_oe, over_oe}, 16'h0003);
		adc <= 16'h0200;
		repeat (1300) @(posedge i_clock);
		chk({14'h0000, crit_oe, over_oe}, 16'h0001);
		adc <= 16'h0000;
		repeat (1300) @(posedge i_clock);
		chk({14'h0000, crit_oe, over_oe}, 16'h0000);
		$display("test comparator done");
		// interrupt mode latches until status read
		acc(8'h03, 1, 16'h1400);
		// drop flags left from comparator runs so only a fresh event latches
		acc(8'h02, 0, 16'h0000);
		repeat (10) @(posedge i_clock);
		chk({14'h0000, crit_oe, over_oe}, 16'h0000);
		adc <= 16'h0c8f;
		repeat (1300) @(posedge i_clock);
		adc <= 16'h0000;
		repeat (1300) @(posedge i_clock);
		chk({14'h0000, crit_oe, over_oe}, 16'h0003);
		acc(8'h02, 0, 16'h0000);
		chk(v, 16'hd014);
		repeat (10) @(posedge i_clock);
		chk({14'h0000, crit_oe, over_oe}, 16'h0000);
		$display("test interrupt done");
		// resolution select, negative value
		acc(8'h03, 1, 16'h8000);
		adc <= 16'hf3a7;
		repeat (1300) @(posedge i_clock);
		acc(8'h00, 0, 16'h0000);
		chk(v, 16'hf3a7);
		acc(8'h03, 1, 16'h0000);
		repeat (1300) @(posedge i_clock);
		acc(8'h00, 0, 16'h0000);
		chk(v, 16'hf3a0);
		$display("test resolution done");
		// shutdown, one-shot, slow sampling
		acc(8'h03, 1, 16'h6000);
		repeat (20) @(posedge i_clock);
		chk({15'h0000, adc_en}, 16'h0000);
		acc(8'h03, 1, 16'h2000);
		repeat (20) @(posedge i_clock);
		chk({15'h0000, adc_en}, 16'h0001);
		repeat (1000) @(posedge i_clock);
		chk({15'h0000, adc_en}, 16'h0000);
		acc(8'h03, 1, 16'h4000);
		chk({15'h0000, samples_per_second_mode}, 16'h0001);
		on = 0;
		// two full periods, so a start-to-start interval is seen
		repeat (8000) begin
			@(posedge i_clock);
			on += int'(adc_en);
		end
		chk({15'h0000, on >= 476 && on <= 484}, 16'h0001);
		$display("test modes done");
		// second reset: critical limit back, fast first result
		adc <= 16'h0c8f;
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (5) @(posedge i_clock);
		acc(8'h00, 0, 16'h0000);
		chk(v, 16'h0c88);
		acc(8'h08, 0, 16'h0000);
		chk(v, 16'h4980);
		$display("test second reset done");
		finish_test();
	end
endmodule
